// file: common/lsbm_cfg.svh
// Offsets, field positions, reset values and timing figures of the switch and battery-measure bank
`ifndef LSBM_CFG_SVH
`define LSBM_CFG_SVH
// Register offsets
`define LSBM_OFS_SWITCH_CFG   8'h0C
`define LSBM_OFS_BAT_TIMING   8'h0D
`define LSBM_OFS_BAT_CFG      8'h0E
// power_switch_config fields
`define LSBM_SW_SEQ_HI        7
`define LSBM_SW_SEQ_LO        5
`define LSBM_SW_EN_HI         2
`define LSBM_SW_EN_LO         1
`define LSBM_SW_SOFT_BIT      0
`define LSBM_SW_SEQ_REGCTL    3'h7
`define LSBM_SW_EN_OFF        2'h0
`define LSBM_SW_EN_ON         2'h1
`define LSBM_SW_EN_PIN        2'h2
// battery_measure_timing fields
`define LSBM_CELL_HI          5
`define LSBM_CELL_LO          4
`define LSBM_OPEN_HI          3
`define LSBM_OPEN_LO          2
`define LSBM_LOAD_HI          1
`define LSBM_LOAD_LO          0
`define LSBM_CELL_SKIP        2'h0
// battery_measure_config fields
`define LSBM_ACTIVE_BIT       7
`define LSBM_ABORT_BIT        6
`define LSBM_SKIP2_BIT        3
`define LSBM_CUR_HI           2
`define LSBM_CUR_LO           0
// Reset values of writable fields
`define LSBM_RST_2B           2'h0
`define LSBM_RST_3B           3'h0
// Timing figures
`define LSBM_CLK_KHZ          100000
`define LSBM_SOFTSTART_MS     60
`define LSBM_CELL_DLY1_MS     10
`define LSBM_CELL_DLY2_MS     100
`define LSBM_CELL_DLY3_MS     1000
`endif

// file: common/lsbm_pkg.sv
// Types of the switch and battery-measure bank
`default_nettype none
package lsbm_pkg;
  typedef enum logic [1:0] {
    LSBM_PH_IDLE      = 2'b00,
    LSBM_PH_CELL_WAIT = 2'b01,
    LSBM_PH_MEASURE   = 2'b10
  } lsbm_phase_e;
  typedef logic [26:0] lsbm_cnt_t;
endpackage
`default_nettype wire

// file: hdl/lsbm_ctrl.sv
// Switch configuration and battery impedance sequencer register bank
`timescale 1ns/1ps
`default_nettype none
`include "lsbm_cfg.svh"
module lsbm_ctrl #(
  parameter int SOFTSTART_CYC = `LSBM_SOFTSTART_MS * `LSBM_CLK_KHZ,
  parameter int CELL_DLY1_CYC = `LSBM_CELL_DLY1_MS * `LSBM_CLK_KHZ,
  parameter int CELL_DLY2_CYC = `LSBM_CELL_DLY2_MS * `LSBM_CLK_KHZ,
  parameter int CELL_DLY3_CYC = `LSBM_CELL_DLY3_MS * `LSBM_CLK_KHZ
) (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  // Register access
  input  wire logic [7:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output var  logic [7:0]           reg_rdata,
  // Sequencer and pin inputs
  input  wire logic [2:0]           switch_sequence_cfg,
  input  wire logic                 seq_switch_req,
  input  wire logic                 multipurpose_control_pin,
  input  wire logic                 impedance_done,
  // Switch control
  output var  logic                 switch_on,
  output var  logic                 switch_current_limit,
  // Measurement control
  output var  logic                 impedance_run,
  output var  logic                 cell_measure_strobe,
  output var  logic [1:0]           open_voltage_timing,
  output var  logic [1:0]           loaded_voltage_timing,
  output var  logic                 loaded_delay_second_skip,
  output var  logic [2:0]           impedance_current_sel
);
  import lsbm_pkg::*;

  logic [1:0]   switch_enable_ctl;
  logic         switch_softstart_sel;
  logic [1:0]   cell_voltage_timing;
  logic         impedance_abort;
  logic         pin_meta;
  logic         pin_sync;
  logic         next_switch_on;
  lsbm_phase_e  phase;
  lsbm_cnt_t    wait_cnt;
  lsbm_cnt_t    ss_cnt;
  logic         wr_sw;
  logic         wr_tm;
  logic         wr_bc;
  logic         start_req;
  logic         abort_req;

  // Cycle count of each cell timing code
  function automatic lsbm_cnt_t cell_target(input logic [1:0] code);
    case (code)
      2'h1:    cell_target = lsbm_cnt_t'(CELL_DLY1_CYC - 1);
      2'h2:    cell_target = lsbm_cnt_t'(CELL_DLY2_CYC - 1);
      default: cell_target = lsbm_cnt_t'(CELL_DLY3_CYC - 1);
    endcase
  endfunction

  // Write decode
  assign wr_sw     = reg_wr && (reg_addr == `LSBM_OFS_SWITCH_CFG);
  assign wr_tm     = reg_wr && (reg_addr == `LSBM_OFS_BAT_TIMING);
  assign wr_bc     = reg_wr && (reg_addr == `LSBM_OFS_BAT_CFG);
  assign abort_req = wr_bc && reg_wdata[`LSBM_ABORT_BIT];
  assign start_req = wr_bc && reg_wdata[`LSBM_ACTIVE_BIT] && !abort_req;

  // Pin synchroniser for the multipurpose control input
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      pin_meta <= multipurpose_control_pin;
      pin_sync <= pin_meta;
    end
  end

  // Writable configuration fields
  always_ff @(posedge core_clk) begin
    if (rst) begin
      switch_enable_ctl        <= `LSBM_RST_2B;
      switch_softstart_sel     <= 1'b0;
      cell_voltage_timing      <= `LSBM_RST_2B;
      open_voltage_timing      <= `LSBM_RST_2B;
      loaded_voltage_timing    <= `LSBM_RST_2B;
      loaded_delay_second_skip <= 1'b0;
      impedance_current_sel    <= `LSBM_RST_3B;
    end else begin
      if (wr_sw) begin
        switch_enable_ctl    <= reg_wdata[`LSBM_SW_EN_HI:`LSBM_SW_EN_LO];
        switch_softstart_sel <= reg_wdata[`LSBM_SW_SOFT_BIT];
      end
      if (wr_tm) begin
        cell_voltage_timing   <= reg_wdata[`LSBM_CELL_HI:`LSBM_CELL_LO];
        open_voltage_timing   <= reg_wdata[`LSBM_OPEN_HI:`LSBM_OPEN_LO];
        loaded_voltage_timing <= reg_wdata[`LSBM_LOAD_HI:`LSBM_LOAD_LO];
      end
      if (wr_bc) begin
        loaded_delay_second_skip <= reg_wdata[`LSBM_SKIP2_BIT];
        impedance_current_sel    <= reg_wdata[`LSBM_CUR_HI:`LSBM_CUR_LO];
      end
    end
  end

  // Switch request: register control only in the 111 sequencing state
  always_comb begin
    if (switch_sequence_cfg == `LSBM_SW_SEQ_REGCTL) begin
      case (switch_enable_ctl)
        `LSBM_SW_EN_ON:  next_switch_on = 1'b1;
        `LSBM_SW_EN_PIN: next_switch_on = pin_sync;
        default:         next_switch_on = 1'b0;
      endcase
    end else begin
      next_switch_on = seq_switch_req;
    end
  end

  // Switch output and soft-start current limit window
  always_ff @(posedge core_clk) begin
    if (rst) begin
      switch_on            <= 1'b0;
      switch_current_limit <= 1'b0;
      ss_cnt               <= '0;
    end else begin
      switch_on <= next_switch_on;
      if (next_switch_on && !switch_on) begin
        switch_current_limit <= switch_softstart_sel;
        ss_cnt               <= '0;
      end else if (!next_switch_on) begin
        switch_current_limit <= 1'b0;
      end else if (switch_current_limit) begin
        if (ss_cnt == lsbm_cnt_t'(SOFTSTART_CYC - 1)) begin
          switch_current_limit <= 1'b0;
        end
        ss_cnt <= ss_cnt + 1'b1;
      end
    end
  end

  // Impedance measurement sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase               <= LSBM_PH_IDLE;
      wait_cnt            <= '0;
      impedance_run       <= 1'b0;
      cell_measure_strobe <= 1'b0;
      impedance_abort     <= 1'b0;
    end else begin
      cell_measure_strobe <= 1'b0;
      if (abort_req && impedance_run) begin
        phase           <= LSBM_PH_IDLE;
        impedance_run   <= 1'b0;
        impedance_abort <= 1'b1;
      end else begin
        case (phase)
          LSBM_PH_IDLE: begin
            if (start_req) begin
              impedance_run   <= 1'b1;
              impedance_abort <= 1'b0;
              wait_cnt        <= '0;
              if (cell_voltage_timing == `LSBM_CELL_SKIP) begin
                phase <= LSBM_PH_MEASURE;
              end else begin
                phase <= LSBM_PH_CELL_WAIT;
              end
            end
          end
          LSBM_PH_CELL_WAIT: begin
            if (wait_cnt == cell_target(cell_voltage_timing)) begin
              cell_measure_strobe <= 1'b1;
              phase               <= LSBM_PH_MEASURE;
            end else begin
              wait_cnt <= wait_cnt + 1'b1;
            end
          end
          LSBM_PH_MEASURE: begin
            if (impedance_done) begin
              phase         <= LSBM_PH_IDLE;
              impedance_run <= 1'b0;
            end
          end
          default: begin
            phase         <= LSBM_PH_IDLE;
            impedance_run <= 1'b0;
          end
        endcase
      end
    end
  end

  // Registered read port, unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `LSBM_OFS_SWITCH_CFG: reg_rdata <= {switch_sequence_cfg, 2'b00, switch_enable_ctl, switch_softstart_sel};
        `LSBM_OFS_BAT_TIMING: reg_rdata <= {2'b00, cell_voltage_timing, open_voltage_timing, loaded_voltage_timing};
        `LSBM_OFS_BAT_CFG:    reg_rdata <= {impedance_run, impedance_abort, 2'b00, loaded_delay_second_skip,
                                            impedance_current_sel};
        default:              reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_softstart_begin: assert property ($rose(switch_on)
                                      |-> switch_current_limit == $past(switch_softstart_sel))
    else $error("Soft-start limit not tied to enable edge");
  a_softstart_end: assert property ($fell(switch_current_limit) && switch_on
                                    |-> $past(ss_cnt) == lsbm_cnt_t'(SOFTSTART_CYC - 1))
    else $error("Soft-start window ended at wrong count");
  a_switch_map: assert property (switch_sequence_cfg == `LSBM_SW_SEQ_REGCTL && $stable(switch_sequence_cfg)
                                 && switch_enable_ctl inside {`LSBM_SW_EN_OFF, `LSBM_SW_EN_ON}
                                 |=> switch_on == $past(switch_enable_ctl[0]))
    else $error("Switch does not follow enable field");
  a_start_idle: assert property (start_req && phase == LSBM_PH_IDLE |=> impedance_run && !impedance_abort)
    else $error("Start write did not start measurement");
  a_start_ignored: assert property (start_req && phase == LSBM_PH_CELL_WAIT
                                    |=> phase != LSBM_PH_IDLE && wait_cnt != '0)
    else $error("Start write disturbed running measurement");
  a_done_clears: assert property (phase == LSBM_PH_MEASURE && impedance_done && !abort_req
                                  |=> !impedance_run && phase == LSBM_PH_IDLE)
    else $error("Active bit did not clear at completion");
  a_cell_skip: assert property (start_req && phase == LSBM_PH_IDLE && cell_voltage_timing == `LSBM_CELL_SKIP
                                |=> phase == LSBM_PH_MEASURE && !cell_measure_strobe)
    else $error("Cell step not skipped");
  a_cell_wait: assert property (cell_measure_strobe |-> $past(phase) == LSBM_PH_CELL_WAIT
                                && $past(wait_cnt) == cell_target($past(cell_voltage_timing)))
    else $error("Cell step taken at wrong time");
  a_abort_stop: assert property (abort_req && impedance_run |=> !impedance_run && impedance_abort
                                 && phase == LSBM_PH_IDLE)
    else $error("Abort did not stop measurement");

  c_start: cover property (start_req && phase == LSBM_PH_IDLE);
  c_complete: cover property (phase == LSBM_PH_MEASURE && impedance_done);
  c_abort: cover property (abort_req && impedance_run);
  c_restart: cover property (start_req && phase == LSBM_PH_CELL_WAIT);
  c_softstart: cover property ($fell(switch_current_limit) && switch_on);
endmodule // lsbm_ctrl
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the switch and battery-measure register bank
`timescale 1ns/1ps
`default_nettype none
`include "lsbm_cfg.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  logic       core_clk, rst, reg_wr, reg_rd, seq_switch_req, multipurpose_control_pin, impedance_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, q;
  logic [2:0] switch_sequence_cfg, impedance_current_sel;
  logic       switch_on, switch_current_limit, impedance_run, cell_measure_strobe, loaded_delay_second_skip;
  logic [1:0] open_voltage_timing, loaded_voltage_timing;
  int         err_count, compares, cyc, k;
  // Short counts keep the run brief
  lsbm_ctrl #(.SOFTSTART_CYC(20), .CELL_DLY1_CYC(4), .CELL_DLY2_CYC(8), .CELL_DLY3_CYC(12)) i_lsbm_ctrl (
    .core_clk                 (core_clk),
    .rst                      (rst),
    .reg_addr                 (reg_addr),
    .reg_wdata                (reg_wdata),
    .reg_wr                   (reg_wr),
    .reg_rd                   (reg_rd),
    .reg_rdata                (reg_rdata),
    .switch_sequence_cfg      (switch_sequence_cfg),
    .seq_switch_req           (seq_switch_req),
    .multipurpose_control_pin (multipurpose_control_pin),
    .impedance_done           (impedance_done),
    .switch_on                (switch_on),
    .switch_current_limit     (switch_current_limit),
    .impedance_run            (impedance_run),
    .cell_measure_strobe      (cell_measure_strobe),
    .open_voltage_timing      (open_voltage_timing),
    .loaded_voltage_timing    (loaded_voltage_timing),
    .loaded_delay_second_skip (loaded_delay_second_skip),
    .impedance_current_sel    (impedance_current_sel)
  );
  // Expected strobe cycle; 40 stands for no strobe
  function automatic int exp_k(input logic [1:0] c);
    return (c == 2'h0) ? 40 : (c == 2'h1) ? 5 : (c == 2'h2) ? 9 : 13;
  endfunction
  // One write strobe, set at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  // One read strobe, data taken a cycle later
  task automatic rd(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    q = reg_rdata;
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Start a measurement with cell code c, check strobe, restart and done
  task automatic meas(input logic [1:0] c, input logic [3:0] lo, input logic [3:0] t);
    wr(`LSBM_OFS_BAT_TIMING, {2'b00, c, t});
    `CHK(open_voltage_timing, t[3:2])
    `CHK(loaded_voltage_timing, t[1:0])
    wr(`LSBM_OFS_BAT_CFG, {4'h8, lo});
    `CHK(impedance_run, 1'b1)
    // Second start inside the cell wait must not restart the count
    wr(`LSBM_OFS_BAT_CFG, {4'h8, lo});
    k = 3;
    while (cell_measure_strobe !== 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    `CHK(k, exp_k(c))
    step(1);
    `CHK(cell_measure_strobe, 1'b0)
    wr(`LSBM_OFS_BAT_CFG, {4'h8, lo});
    `CHK(cell_measure_strobe, 1'b0)
    rd(`LSBM_OFS_BAT_CFG);
    `CHK(q, {4'h8, lo})
    `CHK(impedance_current_sel, lo[2:0])
    `CHK(loaded_delay_second_skip, lo[3])
    impedance_done = 1'b1;
    step(1);
    impedance_done = 1'b0;
    `CHK(impedance_run, 1'b0)
    rd(`LSBM_OFS_BAT_TIMING);
    `CHK(q, {2'b00, c, t})
  endtask
  task automatic complete_run();
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // Hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      complete_run();
    end
  end
  // Main sequence
  initial begin
    {rst, reg_wr, reg_rd, seq_switch_req, multipurpose_control_pin, impedance_done} = 6'b10_0000;
    {reg_addr, reg_wdata} = 16'h0000;
    switch_sequence_cfg = 3'h7;
    {err_count, compares, cyc} = '0;
    void'($urandom(32'h4216e3c2));
    step(12);
    rst = 1'b0;
    rd(`LSBM_OFS_SWITCH_CFG);
    `CHK(q, 8'hE0)
    rd(8'h0F);
    `CHK(q, 8'h00)
    // Every cell code, then random ones
    for (int i = 0; i < 6; i++)
      meas((i < 4) ? i[1:0] : 2'($urandom), 4'($urandom), 4'($urandom));
    // Abort while running, then idle abort, then fresh start
    wr(`LSBM_OFS_BAT_CFG, 8'h80);
    wr(`LSBM_OFS_BAT_CFG, 8'h40);
    `CHK(impedance_run, 1'b0)
    wr(`LSBM_OFS_BAT_CFG, 8'h40);
    rd(`LSBM_OFS_BAT_CFG);
    `CHK(q, 8'h40)
    wr(`LSBM_OFS_BAT_CFG, 8'h80);
    rd(`LSBM_OFS_BAT_CFG);
    `CHK(q, 8'h80)
    wr(`LSBM_OFS_BAT_CFG, 8'h40);
    // Soft-start enable, limit length in cycles
    wr(`LSBM_OFS_SWITCH_CFG, 8'h03);
    step(1);
    `CHK({switch_on, switch_current_limit}, 2'b11)
    k = 0;
    while (switch_current_limit === 1'b1 && k < 40) begin
      @(negedge core_clk);
      k++;
    end
    `CHK(k, 20)
    wr(`LSBM_OFS_SWITCH_CFG, 8'h00);
    step(1);
    `CHK(switch_on, 1'b0)
    wr(`LSBM_OFS_SWITCH_CFG, 8'h02);
    step(1);
    `CHK({switch_on, switch_current_limit}, 2'b10)
    wr(`LSBM_OFS_SWITCH_CFG, 8'h06);
    step(1);
    `CHK(switch_on, 1'b0)
    multipurpose_control_pin = 1'b1;
    wr(`LSBM_OFS_SWITCH_CFG, 8'h04);
    step(4);
    `CHK(switch_on, 1'b1)
    // Outside register control the sequencer request rules
    switch_sequence_cfg = 3'h0;
    seq_switch_req = 1'b0;
    wr(`LSBM_OFS_SWITCH_CFG, 8'h02);
    step(2);
    `CHK(switch_on, 1'b0)
    seq_switch_req = 1'b1;
    step(2);
    `CHK(switch_on, 1'b1)
    complete_run();
  end
endmodule // testbench
`default_nettype wire
